/* common/sasidf_pkg.sv */
/*
 * Constants, types and the frame CRC shared by both ends of the
 * identification frame link.
 * Assumes one 40 MHz link-layer clock for both ends.
 */
package sasidf_pkg;

    // Frame geometry
    localparam logic [4:0] IDX_FIRST    = 5'h00;
    localparam logic [4:0] IDX_BODY_END = 5'h1B;
    localparam logic [4:0] IDX_LAST     = 5'h1F;
    localparam int         BODY_BYTES   = 28;
    localparam int         ADDR_BYTES   = 8;

    // Byte positions inside the frame
    localparam int B_TYPE   = 0;
    localparam int B_REASON = 1;
    localparam int B_INIT   = 2;
    localparam int B_TGT    = 3;
    localparam int B_NAME   = 4;
    localparam int B_ADDR   = 12;
    localparam int B_PHY    = 20;
    localparam int B_CAP    = 21;
    localparam int B_PDIS   = 22;

    // Header codes
    localparam logic [3:0] AFT_IDENTIFY = 4'h0;
    localparam logic [3:0] AFT_OPEN     = 4'h1;
    localparam logic [2:0] DEV_END      = 3'h1;
    localparam logic [2:0] INIT_BITS    = 3'h0;
    localparam logic [2:0] TGT_BITS     = 3'h4;

    // Link reset reasons
    localparam logic [3:0] RSN_POWER_ON  = 4'h0;
    localparam logic [3:0] RSN_OPEN      = 4'h1;
    localparam logic [3:0] RSN_HARD_RST  = 4'h2;
    localparam logic [3:0] RSN_SYNC_LOSS = 4'h4;
    localparam logic [3:0] RSN_BREAK_TMO = 4'h7;
    localparam logic [3:0] RSN_PHY_TEST  = 4'h8;

    // Power capable codes
    localparam logic [1:0] PWRC_NONE     = 2'h0;
    localparam logic [1:0] PWRC_CONSUMER = 2'h1;
    localparam logic [1:0] PWRC_MANAGER  = 2'h2;
    localparam logic [1:0] PWRC_RSVD     = 2'h3;

    // Capability bit values
    localparam logic PERSIST_CAP  = 1'b0;
    localparam logic ZONE_PERSIST = 1'b0;
    localparam logic ZONE_REQ     = 1'b0;
    localparam logic BRK_REPLY_OK = 1'b1;
    localparam logic PWR_DIS_OK   = 1'b1;

    // Frame CRC
    localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

    // Link FIFO shape: data byte plus start and end marks
    localparam int LNK_W      = 10;
    localparam int FIFO_DEPTH = 8;

    // Primitives exchanged beside the frames
    typedef enum logic [3:0] {
        PR_NONE        = 4'h0,
        PR_PWR_REQ     = 4'h1,
        PR_PWR_DONE    = 4'h2,
        PR_PWR_ACK     = 4'h3,
        PR_PWR_GRANT   = 4'h4,
        PR_BREAK       = 4'h5,
        PR_BREAK_REPLY = 4'h6,
        PR_COMINIT     = 4'h7,
        PR_COMWAKE     = 4'h8
    } sasidf_prim_e;

    // One byte into the CRC, most significant bit first
    function automatic logic [31:0] sasidf_crc_byte(
        input logic [31:0] c,
        input logic [7:0]  d
    );
        logic [31:0] r;
        r = c;
        for (int i = 7; i >= 0; i--)
        begin
            r = (r[31] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

endpackage

/* common/sasidf_link_if.sv */
/*
 * Link between the device end and the far phy end.
 * Assumes both ends share the clock given to the interface.
 */
`timescale 1ns/1ps
interface sasidf_link_if
    import sasidf_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_nrst
);
    logic         afr_valid;
    logic         afr_ready;
    logic [7:0]   afr_data;
    logic         afr_sof;
    logic         afr_eof;
    sasidf_prim_e dprim;
    sasidf_prim_e hprim;
    logic         phy_ready;
    logic         conn_open;

    modport dev_mp (
        output afr_valid, afr_data, afr_sof, afr_eof, dprim,
        input  afr_ready, hprim, phy_ready, conn_open
    );

    modport host_mp (
        input  afr_valid, afr_data, afr_sof, afr_eof, dprim,
        output afr_ready, hprim, phy_ready, conn_open
    );
endinterface

/* verilog/sasidf_dev.sv */
/*
 * Device end: identification frame builder feeding the link FIFO,
 * with power, break and low power primitive handling.
 * Assumes the far end drives phy_ready, conn_open and the primitives
 * on the same clock, and keeps its own side of the link.
 */
// What this block does
// - Byte 0: reserved, device type, frame type
// - Frame type 0 identify, 1 open
// - Frames sent only with no connection open
// - Identify sent only after phy reset completes
// - Device type 001b, frame type zero
// - All three initiator bits cleared
// - Target bits set to 100b
// - Name, address, phy identifier in place
// - Reason nibble reports link reset cause
// - Persistent connection bit cleared
// - Both zoning bits cleared
// - Power code 00b: no power primitives
// - Code 01b: request, done, acknowledge grant
// - Code 10b: manager acknowledges and grants; this block has no manager logic and sends no power primitives then
// - One power request outstanding at most
// - Low power held off during extra power
// - Slumber bit, slumber wakes on COM only
// - Partial bit, partial wakes on COM only
// - Break reply bit set, break answered
// - Power disable bit set, rest zero
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module sasidf_dev
    import sasidf_pkg::*;
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    // Link to the far phy
    sasidf_link_if.dev_mp    lnk,
    // Identity contents
    input  wire logic [63:0] i_dev_name,
    input  wire logic [63:0] i_sas_addr,
    input  wire logic [7:0]  i_phy_id,
    input  wire logic [3:0]  i_reason,
    // Advertised capabilities
    input  wire logic [1:0]  i_pwr_cap,
    input  wire logic        i_slumber_en,
    input  wire logic        i_partial_en,
    // Power consumer requests
    input  wire logic        i_pwr_req,
    input  wire logic        i_pwr_done,
    input  wire logic        i_low_power,
    output logic             o_pwr_granted,
    output logic             o_lp_disable,
    // Phy power conditions
    input  wire logic        i_enter_slumber,
    input  wire logic        i_enter_partial,
    output logic             o_slumber,
    output logic             o_partial,
    // Status
    output logic             o_id_sent
);
    // Gray codes along the send path
    typedef enum logic [1:0] {
        ID_WAIT = 2'b00,
        ID_BODY = 2'b01,
        ID_CRC  = 2'b11,
        ID_DONE = 2'b10
    } sasidf_id_e;
    typedef enum logic [1:0] {
        PW_IDLE = 2'b00,
        PW_WAIT = 2'b01,
        PW_HELD = 2'b11
    } sasidf_pw_e;
    typedef struct packed {
        sasidf_id_e                 id_st;
        logic [4:0]                 idx;
        logic [31:0]                crc;
        logic [BODY_BYTES-1:0][7:0] frm;
        sasidf_pw_e                 pw_st;
        logic                       ack_pend;
        logic                       slumber;
        logic                       partial;
        sasidf_prim_e               dprim;
    } sasidf_dev_s;
    sasidf_dev_s                q;
    sasidf_dev_s                n;
    logic [BODY_BYTES-1:0][7:0] build;
    logic [1:0]                 eff_cap;
    logic [1:0]                 adv_cap;
    logic                       push_vld;
    logic                       push_rdy;
    logic [LNK_W-1:0]           push_data;
    logic [LNK_W-1:0]           pop_data;
    logic [31:0]                crc_fin;
    sasidf_prim_e               rx;
    // Reserved power code is advertised as no power management
    assign eff_cap = (i_pwr_cap == PWRC_RSVD) ? PWRC_NONE : i_pwr_cap;
    assign adv_cap = q.frm[B_CAP][6:5];
    assign crc_fin = (~q.crc) << {q.idx[1:0], 3'b000};
    // Frame contents from the identity inputs
    always_comb
    begin
        build = '0;
        build[B_TYPE] = {1'b0, DEV_END, AFT_IDENTIFY};
        build[B_REASON] = {4'h0, i_reason};
        build[B_INIT][3:1] = INIT_BITS;
        build[B_TGT][3:1] = TGT_BITS;
        for (int i = 0; i < ADDR_BYTES; i++)
        begin
            build[B_NAME + i] = i_dev_name[63 - 8*i -: 8];
            build[B_ADDR + i] = i_sas_addr[63 - 8*i -: 8];
        end
        build[B_PHY] = i_phy_id;
        build[B_CAP] = {PERSIST_CAP, eff_cap, i_slumber_en,
                        i_partial_en, ZONE_PERSIST, ZONE_REQ,
                        BRK_REPLY_OK};
        build[B_PDIS] = {7'h00, PWR_DIS_OK};
    end

    // Frame sender, power handshake and phy power conditions
    always_comb
    begin
        n = q;
        n.dprim = PR_NONE;
        push_vld = 1'b0;
        push_data = '0;
        rx = lnk.hprim;
        case (q.id_st)
            ID_WAIT:
            begin
                if (lnk.phy_ready && !lnk.conn_open)
                begin
                    n.frm = build;
                    n.idx = IDX_FIRST;
                    n.crc = CRC_INIT;
                    n.id_st = ID_BODY;
                end
            end
            ID_BODY:
            begin
                push_vld = 1'b1;
                push_data = {q.idx == IDX_FIRST, 1'b0, q.frm[q.idx]};
                if (push_rdy)
                begin
                    n.crc = sasidf_crc_byte(q.crc, q.frm[q.idx]);
                    n.idx = q.idx + 5'h01;
                    if (q.idx == IDX_BODY_END)
                        n.id_st = ID_CRC;
                end
            end
            ID_CRC:
            begin
                push_vld = 1'b1;
                push_data = {1'b0, q.idx == IDX_LAST, crc_fin[31:24]};
                if (push_rdy)
                begin
                    n.idx = q.idx + 5'h01;
                    if (q.idx == IDX_LAST)
                        n.id_st = ID_DONE;
                end
            end
            default:
            begin
                if (!lnk.phy_ready)
                    n.id_st = ID_WAIT;
            end
        endcase
        // A new phy reset restarts identification
        if (!lnk.phy_ready)
            n.id_st = ID_WAIT;

        // Asleep, only COMINIT or COMWAKE is seen, and it wakes us
        if (q.slumber || q.partial)
        begin
            if (rx == PR_COMINIT || rx == PR_COMWAKE)
            begin
                n.slumber = 1'b0;
                n.partial = 1'b0;
            end
            rx = PR_NONE;
        end

        // Break reply wins the primitive slot
        if (rx == PR_BREAK)
            n.dprim = PR_BREAK_REPLY;

        // Consumer handshake; one request in flight at a time
        case (q.pw_st)
            PW_IDLE:
            begin
                if (adv_cap == PWRC_CONSUMER && i_pwr_req &&
                    !i_low_power && !q.slumber && !q.partial &&
                    n.dprim == PR_NONE)
                begin
                    n.dprim = PR_PWR_REQ;
                    n.pw_st = PW_WAIT;
                end
            end
            PW_WAIT:
            begin
                if (rx == PR_PWR_GRANT)
                begin
                    n.ack_pend = 1'b1;
                    n.pw_st = PW_HELD;
                end
            end
            default:
            begin
                if (i_pwr_done && !q.ack_pend && n.dprim == PR_NONE)
                begin
                    n.dprim = PR_PWR_DONE;
                    n.pw_st = PW_IDLE;
                end
            end
        endcase
        // Acknowledge waits only behind a break reply
        if (q.ack_pend && n.dprim == PR_NONE)
        begin
            n.dprim = PR_PWR_ACK;
            n.ack_pend = 1'b0;
        end

        // Low power barred while extra power is asked for or in use;
        // a request in this very cycle must not be swallowed by sleep
        if (n.pw_st == PW_IDLE && !q.slumber && !q.partial)
        begin
            if (i_enter_slumber && q.frm[B_CAP][4])
                n.slumber = 1'b1;
            else if (i_enter_partial && q.frm[B_CAP][3])
                n.partial = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            q <= '0;
            q.id_st <= ID_WAIT;
            q.pw_st <= PW_IDLE;
            q.dprim <= PR_NONE;
        end
        else
        begin
            q <= n;
        end
    end

    // Link FIFO; the far end may stall it, which stalls the sender
    sasidf_fifo #(
        .WIDTH (LNK_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_mclk      (i_mclk),
        .i_nrst      (i_nrst),
        .i_in_valid  (push_vld),
        .o_in_ready  (push_rdy),
        .i_in_data   (push_data),
        .o_out_valid (lnk.afr_valid),
        .i_out_ready (lnk.afr_ready),
        .o_out_data  (pop_data)
    );

    // Start and end marks stand for the frame delimiters
    assign lnk.afr_sof = pop_data[9];
    assign lnk.afr_eof = pop_data[8];
    assign lnk.afr_data = pop_data[7:0];
    assign lnk.dprim = q.dprim;

    assign o_pwr_granted = (q.pw_st == PW_HELD);
    assign o_lp_disable = (q.pw_st != PW_IDLE);
    assign o_slumber = q.slumber;
    assign o_partial = q.partial;
    assign o_id_sent = (q.id_st == ID_DONE);
endmodule

/* verilog/sasidf_host.sv */
/*
 * Far phy end: receives and checks identification frames and acts
 * as a power manager and break source.
 * Also holds the link FIFO that the device end instantiates.
 * Assumes the device end shares this clock.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module sasidf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_nrst,
    // Fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr;
        logic [AW:0]                 rd;
    } sasidf_fifo_s;

    sasidf_fifo_s q;
    sasidf_fifo_s n;
    logic         full;
    logic         empty;

    // Extra pointer bit tells full from empty
    assign empty = (q.wr == q.rd);
    assign full  = (q.wr[AW] != q.rd[AW]) &&
                   (q.wr[AW-1:0] == q.rd[AW-1:0]);
    assign o_in_ready  = !full;
    assign o_out_valid = !empty;
    assign o_out_data  = q.mem[q.rd[AW-1:0]];

    // Pointer and storage update
    always_comb
    begin
        n = q;
        if (i_in_valid && !full)
        begin
            n.mem[q.wr[AW-1:0]] = i_in_data;
            n.wr = q.wr + 1'b1;
        end
        if (i_out_ready && !empty)
        begin
            n.rd = q.rd + 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            q <= '0;
        else
            q <= n;
    end
endmodule

////////////////////////////////////////////////////////////////////////
module sasidf_host
    import sasidf_pkg::*;
(
    // Clock and reset
    input  wire logic         i_mclk,
    input  wire logic         i_nrst,
    // Link to the device
    sasidf_link_if.host_mp    lnk,
    // Link state from the local phy
    input  wire logic         i_phy_ready,
    input  wire logic         i_conn_open,
    input  wire logic         i_rx_ready,
    // Primitive requests
    input  wire logic         i_pwr_manage,
    input  wire logic         i_send_break,
    input  wire logic         i_send_cominit,
    input  wire logic         i_send_comwake,
    // Received frame
    output logic              o_frame_vld,
    output logic              o_crc_ok,
    output logic [223:0]      o_frame,
    output logic              o_break_replied
);
    typedef struct packed {
        logic [BODY_BYTES-1:0][7:0] buf_b;
        logic [BODY_BYTES-1:0][7:0] frm;
        logic [4:0]                 idx;
        logic [31:0]                crc;
        logic [31:0]                crc_rx;
        logic                       in_frm;
        logic                       frame_vld;
        logic                       crc_ok;
        logic                       grant_pend;
        logic                       brk_rep;
        sasidf_prim_e               hprim;
    } sasidf_host_s;

    sasidf_host_s q;
    sasidf_host_s n;
    logic [4:0]   cur_idx;
    logic [31:0]  cur_crc;
    logic [31:0]  rx_word;

    assign cur_idx = lnk.afr_sof ? IDX_FIRST : q.idx;
    assign cur_crc = lnk.afr_sof ? CRC_INIT : q.crc;
    assign rx_word = {q.crc_rx[23:0], lnk.afr_data};

    // Frame receive and primitive answers
    always_comb
    begin
        n = q;
        n.frame_vld = 1'b0;
        n.brk_rep = 1'b0;
        n.hprim = PR_NONE;
        if (lnk.afr_valid && i_rx_ready && (lnk.afr_sof || q.in_frm))
        begin
            n.in_frm = !lnk.afr_eof;
            n.idx = cur_idx + 5'h01;
            if (cur_idx <= IDX_BODY_END)
            begin
                n.buf_b[cur_idx] = lnk.afr_data;
                n.crc = sasidf_crc_byte(cur_crc, lnk.afr_data);
            end
            else
            begin
                n.crc_rx = rx_word;
            end
            if (lnk.afr_eof)
            begin
                n.frame_vld = 1'b1;
                n.frm = q.buf_b;
                n.crc_ok = (cur_idx == IDX_LAST) && (rx_word == ~q.crc);
            end
        end
        if (lnk.dprim == PR_BREAK_REPLY)
            n.brk_rep = 1'b1;
        // Manager answers: acknowledge a request, then grant on the next slot; done gets acknowledge only
        if (q.grant_pend)
        begin
            n.hprim = PR_PWR_GRANT;
            n.grant_pend = 1'b0;
        end
        else if (i_pwr_manage && lnk.dprim == PR_PWR_REQ)
        begin
            n.hprim = PR_PWR_ACK;
            n.grant_pend = 1'b1;
        end
        else if (i_pwr_manage && lnk.dprim == PR_PWR_DONE)
            n.hprim = PR_PWR_ACK;
        else if (i_send_cominit)
            n.hprim = PR_COMINIT;
        else if (i_send_comwake)
            n.hprim = PR_COMWAKE;
        else if (i_send_break)
            n.hprim = PR_BREAK;
    end

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            q <= '0;
            q.hprim <= PR_NONE;
        end
        else
        begin
            q <= n;
        end
    end

    assign lnk.afr_ready = i_rx_ready;
    assign lnk.phy_ready = i_phy_ready;
    assign lnk.conn_open = i_conn_open;
    assign lnk.hprim = q.hprim;
    assign o_frame_vld = q.frame_vld;
    assign o_crc_ok = q.crc_ok;
    assign o_frame = q.frm;
    assign o_break_replied = q.brk_rep;
endmodule

/* tb/sasidf_assertions.sv */
/*
 * Checker on the link between device end and far phy end.
 * Assumes the bench wires it to the link interface signals.
 */
`timescale 1ns/1ps
module sasidf_assertions
    import sasidf_pkg::*;
(
    // Clock and reset
    input wire logic         i_mclk,
    input wire logic         i_nrst,
    // Link signals
    input wire logic         afr_valid,
    input wire logic         afr_ready,
    input wire logic [7:0]   afr_data,
    input wire logic         afr_sof,
    input wire logic         afr_eof,
    input wire sasidf_prim_e dprim,
    input wire sasidf_prim_e hprim,
    input wire logic         phy_ready,
    input wire logic         conn_open
);
    logic [5:0] cnt_ff;
    logic       outst_ff;
    ////////////////////////////////////////////////////////////////////
    // Bytes taken since start, and power request still open
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cnt_ff   <= 6'h00;
            outst_ff <= 1'b0;
        end
        else
        begin
            if (afr_valid && afr_ready)
                cnt_ff <= afr_sof ? 6'h01 : cnt_ff + 6'h01;
            if (dprim == PR_PWR_REQ)
                outst_ff <= 1'b1;
            else if (dprim == PR_PWR_DONE)
                outst_ff <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    // Manager answer: acknowledge, then grant
    sequence mgr_answer;
        hprim == PR_PWR_ACK ##1 hprim == PR_PWR_GRANT;
    endsequence
    hold_stall_a: assert property (
        afr_valid && !afr_ready |=> afr_valid && $stable(afr_data)
        && $stable(afr_sof)) else $error("byte changed while stalled");
    frame_head_a: assert property (
        afr_valid && afr_sof |-> afr_data == 8'h10)
        else $error("bad header byte");
    frame_len_a: assert property (
        afr_valid && afr_eof |-> cnt_ff == 6'h1F)
        else $error("frame not 32 bytes");
    frame_gate_a: assert property (
        $rose(afr_valid && afr_sof) |-> $past(phy_ready && !conn_open))
        else $error("frame while link not free");
    mgr_answer_a: assert property (
        dprim == PR_PWR_REQ |=> mgr_answer)
        else $error("request not acknowledged and granted");
    done_ack_a: assert property (
        dprim == PR_PWR_DONE |=> hprim == PR_PWR_ACK)
        else $error("done not acknowledged");
    grant_ack_a: assert property (
        hprim == PR_PWR_GRANT |=> ##[0:1] dprim == PR_PWR_ACK)
        else $error("grant not acknowledged");
    one_req_a: assert property (
        dprim == PR_PWR_REQ |-> !outst_ff)
        else $error("second request outstanding");
endmodule

/* tb/tb_top.sv */
/*
 * Bench joining device end and far phy end through the link.
 * Assumes one 40 MHz clock and active low asynchronous reset.
 */
`timescale 1ns/1ps
module tb_top;
    logic         mclk, nrst, sl_en, pa_en, preq, pdone, lowp;
    logic         ent_sl, ent_pa, pgr, lpd, slp, prt, ids, prdy;
    logic         copen, rxr, pman, brk, cinit, cwake, fvld, crc_ok;
    logic         brep;
    logic [63:0]  nm, ad;
    logic [7:0]   pid;
    logic [3:0]   rsn;
    logic [1:0]   cap;
    logic [223:0] frm;
    logic [3:0]   rsns [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h7, 4'h8};
    int           bad_count, check_count, cyc;

    sasidf_link_if lnk_if (.i_mclk(mclk), .i_nrst(nrst));
    sasidf_dev u_sasidf_dev (.i_mclk(mclk), .i_nrst(nrst), .lnk(lnk_if),
        .i_dev_name(nm), .i_sas_addr(ad), .i_phy_id(pid), .i_reason(rsn),
        .i_pwr_cap(cap), .i_slumber_en(sl_en), .i_partial_en(pa_en),
        .i_pwr_req(preq), .i_pwr_done(pdone), .i_low_power(lowp),
        .o_pwr_granted(pgr), .o_lp_disable(lpd), .i_enter_slumber(ent_sl),
        .i_enter_partial(ent_pa), .o_slumber(slp), .o_partial(prt),
        .o_id_sent(ids));
    sasidf_host u_sasidf_host (.i_mclk(mclk), .i_nrst(nrst), .lnk(lnk_if),
        .i_phy_ready(prdy), .i_conn_open(copen), .i_rx_ready(rxr),
        .i_pwr_manage(pman), .i_send_break(brk), .i_send_cominit(cinit),
        .i_send_comwake(cwake), .o_frame_vld(fvld), .o_crc_ok(crc_ok),
        .o_frame(frm), .o_break_replied(brep));
    sasidf_assertions u_chk (.i_mclk(mclk), .i_nrst(nrst),
        .afr_valid(lnk_if.afr_valid), .afr_ready(lnk_if.afr_ready),
        .afr_data(lnk_if.afr_data), .afr_sof(lnk_if.afr_sof),
        .afr_eof(lnk_if.afr_eof), .dprim(lnk_if.dprim),
        .hprim(lnk_if.hprim), .phy_ready(lnk_if.phy_ready),
        .conn_open(lnk_if.conn_open));
    ////////////////////////////////////////////////////////////////////
    // Expected body bytes 0..27 from the identity inputs
    function automatic logic [223:0] exp_frame();
        logic [223:0] f;
        f = '0;
        f[7:0] = 8'h10;
        f[15:8] = {4'h0, rsn};
        f[31:24] = 8'h08;
        for (int i = 0; i < 8; i++)
        begin
            f[8*(4+i) +: 8] = nm[8*(7-i) +: 8];
            f[8*(12+i) +: 8] = ad[8*(7-i) +: 8];
        end
        f[167:160] = pid;
        // Reserved power code goes out as none
        f[175:168] = {1'b0, (cap == 2'h3) ? 2'h0 : cap, sl_en, pa_en, 3'h1};
        f[183:176] = 8'h01;
        return f;
    endfunction

    task automatic chk(input logic [223:0] g, input logic [223:0] e);
        check_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask

    task automatic give_verdict();
        if (bad_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Drive and sample just after the rising edge
    task automatic tk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wt(ref logic s, input int n);
        for (int k = 0; k < n && s !== 1'b1; k++)
            tk(1);
    endtask

    // One identify frame; odd k starts with a connection open
    task automatic frame(input int k, input logic stall);
        logic [223:0] efr;
        prdy = 1'b0;
        tk(2);
        chk(ids, 1'b0);
        nm = {$urandom, $urandom};
        ad = {$urandom, $urandom};
        pid = 8'($urandom);
        rsn = rsns[k % 6];
        cap = 2'(k);
        sl_en = k[0] | 1'($urandom);
        pa_en = k[0] | 1'($urandom);
        copen = k[0];
        rxr = !stall;
        prdy = 1'b1;
        tk(10);
        if (copen)
            chk(lnk_if.afr_valid, 1'b0);
        copen = 1'b0;
        // Watch from here on: an unstalled frame ends within 35 cycles
        for (int n = 0; n < 330 && fvld !== 1'b1; n++)
        begin
            if (stall && n == 30)
                chk(lnk_if.afr_valid & lnk_if.afr_sof, 1'b1);
            if (n >= 30)
                rxr = stall ? 1'($urandom) : 1'b1;
            tk(1);
        end
        chk(fvld, 1'b1);
        efr = exp_frame();
        chk(frm[63:0], efr[63:0]);
        chk(frm, efr);
        chk(crc_ok, 1'b1);
        chk(ids, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc > 6000)
        begin
            bad_count++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {nrst, sl_en, pa_en, preq, pdone, lowp, ent_sl, ent_pa} = '0;
        {prdy, copen, brk, cinit, cwake, nm, ad, pid, rsn, cap} = '0;
        rxr = 1'b1;
        pman = 1'b1;
        void'($urandom(15));
        repeat (5) @(posedge mclk);
        #1;
        nrst = 1'b1;
        tk(10);
        chk(lnk_if.afr_valid | ids, 1'b0);
        for (int k = 0; k < 13; k++)
            frame(k, k % 3 == 0);
        preq = 1'b1;
        tk(10);
        chk({pgr, lpd}, 2'h0);
        preq = 1'b0;
        frame(13, 1'b0);
        lowp = 1'b1;
        preq = 1'b1;
        tk(10);
        chk(pgr, 1'b0);
        lowp = 1'b0;
        wt(pgr, 10);
        chk({pgr, lpd}, 2'h3);
        // Slumber asked for while extra power is held must wait
        ent_sl = 1'b1;
        tk(3);
        chk(slp, 1'b0);
        ent_sl = 1'b0;
        preq = 1'b0;
        pdone = 1'b1;
        tk(4);
        chk({pgr, lpd}, 2'h0);
        pdone = 1'b0;
        brk = 1'b1;
        tk(1);
        brk = 1'b0;
        wt(brep, 8);
        chk(brep, 1'b1);
        // Slumber then partial: break ignored, COM wakes
        for (int m = 0; m < 2; m++)
        begin
            ent_sl = (m == 0);
            ent_pa = (m == 1);
            tk(3);
            chk({slp, prt}, m ? 2'h1 : 2'h2);
            {ent_sl, ent_pa, brk} = 3'h1;
            tk(1);
            brk = 1'b0;
            wt(brep, 8);
            chk(brep, 1'b0);
            {cwake, cinit} = m ? 2'h1 : 2'h2;
            tk(1);
            {cwake, cinit} = 2'h0;
            tk(4);
            chk({slp, prt}, 2'h0);
        end
        give_verdict();
    end
endmodule
